// ### core/pbc_pkg.sv
// Function
// (RULE1) Edge every bit start, ones add mid edge
// (RULE2) Preamble begins by driving line low
// (RULE3) Receiver syncs despite lost first edge
// (RULE4) Extra trailing edge closes final bit
// (RULE5) Drive line only while transmitting, else release
// (RULE6) Only one party transmits; others stay released
// (RULE7) Disparity stays within half a bit
// (RULE8) Orientation selects exactly one channel line
// (RULE9) Decoder classifies bits by mid-period edge timing
package pbc_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ       = 200;
    localparam int UI_NS         = 3333;
    localparam int HALF_UI_CYC   = UI_NS * CLK_MHZ / 2000;
    localparam int UI_CYC        = 2 * HALF_UI_CYC;
    localparam int SHORT_MAX_CYC = UI_CYC * 3 / 4;
    localparam int IDLE_CYC      = 2 * UI_CYC;
    localparam int LEAD_LOW_CYC  = HALF_UI_CYC;
    localparam int TAIL_CYC      = HALF_UI_CYC;
    localparam int CNT_W         = 12;

    // ****************************************
    // Framing
    // ****************************************
    localparam int PREAMBLE_BITS = 64;
    localparam int SYM_W         = 5;
    localparam int FIFO_DEPTH    = 32;
    localparam int BIT_W         = 7;

    typedef logic [CNT_W-1:0] pbc_cnt_t;
    typedef logic [BIT_W-1:0] pbc_bit_t;

    typedef enum logic [2:0] {
        PBC_IDLE,
        PBC_LEAD_LOW,
        PBC_PREAMBLE,
        PBC_DATA,
        PBC_TAIL
    } pbc_tx_state_e;
endpackage : pbc_pkg

// ### core/pbc_fifo.sv
`timescale 1ns/1ps
module pbc_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    import pbc_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;
    logic [AW-1:0]    rd_next;
    logic [AW:0]      cnt_reg;
    logic [AW:0]      cnt_next;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_next  = push ? AW'((wr_reg + 1'b1) % DEPTH) : wr_reg;
        rd_next  = pop ? AW'((rd_reg + 1'b1) % DEPTH) : rd_reg;
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule : pbc_fifo

// ### core/pbc_bmc_rx.sv
`timescale 1ns/1ps
module pbc_bmc_rx (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic line_in,
    output logic      bit_valid,
    output logic      bit_value,
    output logic      frame_end,
    output logic      active
);
    import pbc_pkg::*;

    logic     prev_reg;
    logic     prev_next;
    logic     act_reg;
    logic     act_next;
    logic     half_reg;
    logic     half_next;
    pbc_cnt_t cnt_reg;
    pbc_cnt_t cnt_next;
    logic     bv_reg;
    logic     bv_next;
    logic     bval_reg;
    logic     bval_next;
    logic     end_reg;
    logic     end_next;
    logic     edge_seen;

    assign edge_seen = line_in ^ prev_reg;
    assign bit_valid = bv_reg;
    assign bit_value = bval_reg;
    assign frame_end = end_reg;
    assign active    = act_reg;

    always_comb begin
        prev_next = line_in;
        act_next  = act_reg;
        half_next = half_reg;
        cnt_next  = cnt_reg;
        bv_next   = 1'b0;
        bval_next = bval_reg;
        end_next  = 1'b0;
        if (!enable) begin
            act_next  = 1'b0;
            half_next = 1'b0;
            cnt_next  = '0;
        end else if (edge_seen) begin
            cnt_next = '0;
            if (!act_reg) begin
                // Any edge starts timing; a lost lead edge costs the first bit
                act_next  = 1'b1; // see (RULE3)
                half_next = 1'b0;
            end else if (cnt_reg < CNT_W'(SHORT_MAX_CYC)) begin
                // Short gap: a mid-period edge
                half_next = !half_reg; // see (RULE9)
                if (half_reg) begin
                    bv_next   = 1'b1;
                    bval_next = 1'b1; // see (RULE1)
                end
            end else begin
                // Full gap: zero; a stray half is dropped to resync
                half_next = 1'b0; // see (RULE3)
                bv_next   = 1'b1;
                bval_next = 1'b0; // see (RULE9)
            end
        end else if (act_reg) begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == CNT_W'(IDLE_CYC)) begin
                act_next  = 1'b0;
                half_next = 1'b0;
                end_next  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prev_reg <= 1'b0;
            act_reg  <= 1'b0;
            half_reg <= 1'b0;
            cnt_reg  <= '0;
            bv_reg   <= 1'b0;
            bval_reg <= 1'b0;
            end_reg  <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            act_reg  <= act_next;
            half_reg <= half_next;
            cnt_reg  <= cnt_next;
            bv_reg   <= bv_next;
            bval_reg <= bval_next;
            end_reg  <= end_next;
        end
    end
endmodule : pbc_bmc_rx

// ### core/pbc_codec.sv
`timescale 1ns/1ps
module pbc_codec #(
    parameter int DEPTH = pbc_pkg::FIFO_DEPTH
) (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    orient_b,
    input  wire logic                    tx_valid,
    output logic                         tx_ready,
    input  wire logic [pbc_pkg::SYM_W-1:0] tx_symbol,
    input  wire logic                    tx_last,
    output logic                         tx_busy,
    output logic                         tx_underrun,
    output logic                         rx_bit_valid,
    output logic                         rx_bit,
    output logic                         rx_frame_end,
    output logic                         rx_active,
    input  wire logic                    channel_line_a_in,
    output logic                         channel_line_a_out,
    output logic                         channel_line_a_oe,
    input  wire logic                    channel_line_b_in,
    output logic                         channel_line_b_out,
    output logic                         channel_line_b_oe
);
    import pbc_pkg::*;

    // ****************************************
    // Transmit queue
    // ****************************************
    logic             q_valid;
    logic             q_pop;
    logic [SYM_W:0]   q_data;

    pbc_fifo #(
        .WIDTH (SYM_W + 1),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   ({tx_last, tx_symbol}),
        .out_valid (q_valid),
        .out_ready (q_pop),
        .out_data  (q_data)
    );

    // ****************************************
    // Channel line selection
    // ****************************************
    logic line_rx;
    logic line_lvl_reg;
    logic line_oe_reg;

    assign line_rx            = orient_b ? channel_line_b_in : channel_line_a_in; // see (RULE8)
    assign channel_line_a_out = orient_b ? 1'b0 : line_lvl_reg;
    assign channel_line_b_out = orient_b ? line_lvl_reg : 1'b0;
    assign channel_line_a_oe  = line_oe_reg && !orient_b; // see (RULE8)
    assign channel_line_b_oe  = line_oe_reg && orient_b; // see (RULE8)

    // ****************************************
    // Receive decoder
    // ****************************************
    pbc_bmc_rx u_rx (
        .clk       (clk),
        .reset     (reset),
        .enable    (!line_oe_reg),
        .line_in   (line_rx),
        .bit_valid (rx_bit_valid),
        .bit_value (rx_bit),
        .frame_end (rx_frame_end),
        .active    (rx_active)
    );

    // ****************************************
    // Transmit encoder
    // ****************************************
    pbc_tx_state_e    st_reg;
    pbc_tx_state_e    st_next;
    pbc_cnt_t         cnt_reg;
    pbc_cnt_t         cnt_next;
    logic             phase_reg;
    logic             phase_next;
    pbc_bit_t         bit_reg;
    pbc_bit_t         bit_next;
    logic [SYM_W-1:0] sh_reg;
    logic [SYM_W-1:0] sh_next;
    logic             last_reg;
    logic             last_next;
    logic             lvl_next;
    logic             oe_next;
    logic             urun_reg;
    logic             urun_next;
    logic             half_done;
    logic             cur_bit;

    assign tx_busy     = (st_reg != PBC_IDLE);
    assign tx_underrun = urun_reg;
    assign half_done   = (cnt_reg == CNT_W'(HALF_UI_CYC - 1));
    assign cur_bit     = (st_reg == PBC_PREAMBLE) ? bit_reg[0] : sh_reg[0];
    assign q_pop       = q_valid && half_done && phase_reg
                         && (((st_reg == PBC_PREAMBLE)
                              && (bit_reg == BIT_W'(PREAMBLE_BITS - 1)))
                             || ((st_reg == PBC_DATA)
                                 && (bit_reg == BIT_W'(SYM_W - 1)) && !last_reg));

    always_comb begin
        st_next    = st_reg;
        cnt_next   = cnt_reg + 1'b1;
        phase_next = phase_reg;
        bit_next   = bit_reg;
        sh_next    = sh_reg;
        last_next  = last_reg;
        lvl_next   = line_lvl_reg;
        oe_next    = line_oe_reg;
        urun_next  = 1'b0;
        unique case (st_reg)
            PBC_IDLE: begin
                cnt_next = '0;
                oe_next  = 1'b0; // see (RULE5)
                lvl_next = 1'b0;
                // Wait for a quiet wire before taking it
                if (q_valid && !rx_active) begin // see (RULE6)
                    st_next  = PBC_LEAD_LOW;
                    oe_next  = 1'b1; // see (RULE5)
                    lvl_next = 1'b0; // see (RULE2)
                end
            end
            PBC_LEAD_LOW: begin
                if (cnt_reg == CNT_W'(LEAD_LOW_CYC - 1)) begin
                    st_next    = PBC_PREAMBLE;
                    cnt_next   = '0;
                    phase_next = 1'b0;
                    bit_next   = '0;
                    lvl_next   = !line_lvl_reg; // see (RULE1)
                end
            end
            PBC_PREAMBLE, PBC_DATA: begin
                if (half_done) begin
                    cnt_next = '0;
                    if (!phase_reg) begin
                        phase_next = 1'b1;
                        // Ones toggle mid-cell; balance holds by construction
                        if (cur_bit) begin
                            lvl_next = !line_lvl_reg; // see (RULE1) (RULE7)
                        end
                    end else begin
                        phase_next = 1'b0;
                        bit_next   = bit_reg + 1'b1;
                        sh_next    = sh_reg >> 1;
                        lvl_next   = !line_lvl_reg; // see (RULE1)
                        if (q_pop) begin
                            st_next   = PBC_DATA;
                            bit_next  = '0;
                            sh_next   = q_data[SYM_W-1:0];
                            last_next = q_data[SYM_W];
                        end else if ((st_reg == PBC_DATA)
                                     && (bit_reg == BIT_W'(SYM_W - 1))) begin
                            // Closing edge lets the far end clock the last bit
                            st_next   = PBC_TAIL; // see (RULE4)
                            urun_next = !last_reg;
                        end else if ((st_reg == PBC_PREAMBLE)
                                     && (bit_reg == BIT_W'(PREAMBLE_BITS - 1))) begin
                            st_next   = PBC_TAIL; // see (RULE4)
                            urun_next = 1'b1;
                        end
                    end
                end
            end
            PBC_TAIL: begin
                if (cnt_reg == CNT_W'(TAIL_CYC - 1)) begin
                    st_next  = PBC_IDLE;
                    cnt_next = '0;
                    oe_next  = 1'b0; // see (RULE5) (RULE6)
                    lvl_next = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_reg       <= PBC_IDLE;
            cnt_reg      <= '0;
            phase_reg    <= 1'b0;
            bit_reg      <= '0;
            sh_reg       <= '0;
            last_reg     <= 1'b0;
            line_lvl_reg <= 1'b0;
            line_oe_reg  <= 1'b0;
            urun_reg     <= 1'b0;
        end else begin
            st_reg       <= st_next;
            cnt_reg      <= cnt_next;
            phase_reg    <= phase_next;
            bit_reg      <= bit_next;
            sh_reg       <= sh_next;
            last_reg     <= last_next;
            line_lvl_reg <= lvl_next;
            line_oe_reg  <= oe_next;
            urun_reg     <= urun_next;
        end
    end
endmodule : pbc_codec

// ### tb/pbc_codec_assertions.sv
`timescale 1ns/1ps
module pbc_codec_assertions
    import pbc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic orient_b,
    input wire logic tx_busy,
    input wire logic rx_bit_valid,
    input wire logic rx_frame_end,
    input wire logic rx_active,
    input wire logic channel_line_a_in,
    input wire logic channel_line_a_out,
    input wire logic channel_line_a_oe,
    input wire logic channel_line_b_in,
    input wire logic channel_line_b_out,
    input wire logic channel_line_b_oe
);
    // ****
    // Edge run counters
    // ****
    logic     sel_oe;
    logic     sel_out;
    logic     sel_in;
    logic     out_reg;
    logic     in_reg;
    pbc_cnt_t orun_reg;
    pbc_cnt_t irun_reg;

    assign sel_oe  = orient_b ? channel_line_b_oe : channel_line_a_oe;
    assign sel_out = orient_b ? channel_line_b_out : channel_line_a_out;
    assign sel_in  = orient_b ? channel_line_b_in : channel_line_a_in;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_reg  <= 1'b0;
            in_reg   <= 1'b0;
            orun_reg <= 12'h001;
            irun_reg <= 12'h001;
        end else begin
            out_reg  <= sel_out;
            in_reg   <= sel_in;
            orun_reg <= (!sel_oe || sel_out != out_reg) ? 12'h001
                        : orun_reg + {11'h000, ~&orun_reg};
            irun_reg <= (sel_in != in_reg) ? 12'h001 : irun_reg + {11'h000, ~&irun_reg};
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    chk_edge_spacing: assert property (
        sel_oe && sel_out != out_reg |-> orun_reg inside {[331:335], [664:668]})
        else $error("line edge spacing off");
    chk_lead_low: assert property (
        $rose(sel_oe) |-> !sel_out [*8]) else $error("no low lead");
    chk_tail_hold: assert property (
        $fell(sel_oe) |-> $past(orun_reg) inside {[331:335]}) else $error("tail hold off");
    chk_idle_release: assert property (
        !tx_busy |-> !channel_line_a_oe && !channel_line_b_oe) else $error("driven idle");
    chk_one_line: assert property (
        !(orient_b ? channel_line_a_oe : channel_line_b_oe)) else $error("wrong line driven");
    chk_no_talk_over: assert property (
        $rose(tx_busy) |-> !$past(rx_active)) else $error("tx over rx");
    chk_quiet_own: assert property (
        sel_oe |-> !rx_bit_valid) else $error("decoded own tx");
    chk_frame_end: assert property (
        rx_frame_end |-> !rx_active && irun_reg inside {[1330:1340]})
        else $error("frame end timing off");
    chk_bit_latency: assert property (
        rx_bit_valid |-> irun_reg inside {[1:4]}) else $error("bit late");
endmodule : pbc_codec_assertions

bind pbc_codec pbc_codec_assertions u_chk (.clk(clk), .reset(reset), .orient_b(orient_b),
    .tx_busy(tx_busy), .rx_bit_valid(rx_bit_valid), .rx_frame_end(rx_frame_end),
    .rx_active(rx_active), .channel_line_a_in(channel_line_a_in),
    .channel_line_a_out(channel_line_a_out), .channel_line_a_oe(channel_line_a_oe),
    .channel_line_b_in(channel_line_b_in), .channel_line_b_out(channel_line_b_out),
    .channel_line_b_oe(channel_line_b_oe));

// ### tb/pbc_far_end.sv
`timescale 1ns/1ps
module pbc_far_end
    import pbc_pkg::*;
(
    input  wire logic clk,
    input  wire logic line,
    output logic      out,
    output logic      oe
);
    // ****
    // Remote codec
    // ****
    logic [79:0] bits = '0;
    int          n = 0;
    int          gap = 4000;
    logic        half = 1'b0;
    logic        last = 1'b0;

    initial begin
        out = 1'b0;
        oe  = 1'b0;
    end

    // Decode while released
    always @(posedge clk) begin
        if (!oe && line !== last) begin
            if (gap >= 1000) half = 1'b0;
            else if (gap < 499) begin
                if (half) bits = {bits[78:0], 1'b1};
                if (half) n++;
                half = !half;
            end else begin
                bits = {bits[78:0], 1'b0};
                n++;
            end
            gap = 0;
        end else if (gap < 4000) gap++;
        last = line;
    end

    task automatic halfbit;
        repeat (HALF_UI_CYC) @(posedge clk);
    endtask : halfbit

    task automatic send(input logic [31:0] b, input int nb, input logic skip);
        logic lv;
        lv = 1'b0;
        @(posedge clk);
        oe  <= 1'b1;
        out <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            if (!(skip && i == 0)) lv = !lv;
            out <= lv;
            halfbit();
            if (b[i]) lv = !lv;
            out <= lv;
            halfbit();
        end
        out <= !lv;
        halfbit();
        oe  <= 1'b0;
        out <= 1'b0;
    endtask : send
endmodule : pbc_far_end

// ### tb/test_pbc_codec.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_pbc_codec
    import pbc_pkg::*;
;
    logic             clk = 1'b0;
    logic             reset = 1'b1;
    logic             orient_b = 1'b1;
    logic             tx_valid = 1'b0;
    logic             tx_last = 1'b0;
    logic [SYM_W-1:0] tx_symbol = '0;
    logic             tx_ready, tx_busy, tx_underrun, rx_bit_valid, rx_bit, rx_frame_end;
    logic             rx_active, a_out, a_oe, b_out, b_oe, far_out, far_oe, a_line, b_line;
    logic [31:0]      rxs = '0;
    int               bad_count = 0, n_tests = 0, rxn = 0, cyc = 0;

    // Pull to low when nobody drives
    assign a_line = a_oe ? a_out : (far_oe ? far_out : 1'b0);
    assign b_line = b_oe ? b_out : 1'b0;
    always #2.5 clk = ~clk;

    pbc_codec #(.DEPTH(FIFO_DEPTH)) DUT (.clk(clk), .reset(reset), .orient_b(orient_b),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_symbol(tx_symbol), .tx_last(tx_last),
        .tx_busy(tx_busy), .tx_underrun(tx_underrun), .rx_bit_valid(rx_bit_valid),
        .rx_bit(rx_bit), .rx_frame_end(rx_frame_end), .rx_active(rx_active),
        .channel_line_a_in(a_line), .channel_line_a_out(a_out), .channel_line_a_oe(a_oe),
        .channel_line_b_in(b_line), .channel_line_b_out(b_out), .channel_line_b_oe(b_oe));
    pbc_far_end u_far (.clk(clk), .line(a_line), .out(far_out), .oe(far_oe));

    always @(posedge clk) begin
        cyc++;
        if (rx_bit_valid === 1'b1) rxs = {rxs[30:0], rx_bit};
        if (rx_bit_valid === 1'b1) rxn++;
        if (cyc == 90000) bad_count++;
        if (cyc == 90000) complete_run();
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic push(input logic [5:0] w);
        tx_valid <= 1'b1;
        {tx_last, tx_symbol} <= w;
        @(negedge clk);
        while (tx_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
    endtask : push

    // Queue fills while the lead-low phase runs, then reset aborts
    task automatic test_fill;
        for (int i = 0; i < FIFO_DEPTH; i++) push({1'b0, 5'(i)});
        tx_valid <= 1'b0;
        @(negedge clk);
        `CHK("tx_ready full", 1'b0, tx_ready)
        `CHK("b_oe", 1'b1, b_oe)
        `CHK("a_oe", 1'b0, a_oe)
        `CHK("b_out", 1'b0, b_out)
        @(posedge clk);
        reset <= 1'b1;
        @(negedge clk);
        `CHK("b_oe reset", 1'b0, b_oe)
        `CHK("tx_ready reset", 1'b1, tx_ready)
        @(posedge clk);
        reset    <= 1'b0;
        orient_b <= 1'b0;
        $display("fill test done");
    endtask : test_fill

    // Frame in with lost first edge, queued packet waits, then goes out
    task automatic test_link;
        logic [31:0] b;
        logic [31:0] e;
        int          t;
        logic        seen;
        b = {8'h00, 8'hc5, 16'haaaa};
        e = '0;
        for (int i = 1; i < 24; i++) e = {e[30:0], b[i]};
        fork
            u_far.send(b, 24, 1'b1);
            begin
                repeat (3000) @(posedge clk);
                push({1'b1, 5'h16});
                tx_valid <= 1'b0;
            end
        join
        t = 0;
        do begin @(negedge clk); t++; end while (rx_frame_end !== 1'b1 && t < 3000);
        `CHK("rx frame end", 1'b1, rx_frame_end)
        `CHK("rx count", 32'd23, 32'(rxn))
        `CHK("rx data", e, rxs)
        `CHK("busy in rx", 1'b0, tx_busy)
        u_far.n = 0;
        t = 0;
        seen = 1'b0;
        do begin @(negedge clk); t++; end while (tx_busy !== 1'b1 && t < 10);
        do begin
            @(negedge clk);
            t++;
            seen = seen | (tx_underrun !== 1'b0);
        end while (tx_busy !== 1'b0 && t < 60000);
        repeat (5) @(negedge clk);
        `CHK("tx busy end", 1'b0, tx_busy)
        `CHK("underrun", 1'b0, seen)
        `CHK("far count", 32'd69, 32'(u_far.n))
        `CHK("preamble", 64'h5555555555555555, u_far.bits[68:5])
        `CHK("symbol", 5'b01101, u_far.bits[4:0])
        `CHK("a_oe idle", 1'b0, a_oe)
        $display("link test done");
    endtask : test_link

    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        test_fill();
        test_link();
        complete_run();
    end
endmodule : test_pbc_codec
